// *** logic/cfs_pkg.sv ***
/*
 * Constants shared by the link fault supervisor: register map, field
 * positions, reset values, setting codes and loss timer resolution.
 * Assumes a 100 MHz system clock.
 */
`default_nettype none
package cfs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int LOSS_TICK_NS     = 100_000_000;
  localparam int LOSS_TICK_CYCLES = LOSS_TICK_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Setting codes
  localparam logic [13:0] SET_OFF      = 14'h270F;
  localparam logic [13:0] RETRY_MAX    = 14'h000A;
  localparam logic [13:0] INTERVAL_MAX = 14'h270E;
  localparam logic [7:0]  TERM_POS     = 8'h62;
  localparam logic [7:0]  TERM_NEG     = 8'hC6;
  localparam logic [1:0]  MODE_COAST   = 2'h0;
  localparam logic [1:0]  MODE_DECEL   = 2'h1;
  localparam logic [1:0]  MODE_AUTO    = 2'h2;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_RETRY    = 8'h00;
  localparam logic [7:0] ADDR_INTERVAL = 8'h04;
  localparam logic [7:0] ADDR_CONFIG   = 8'h08;
  localparam logic [7:0] ADDR_GROUP    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_MASK     = 8'h14;
  localparam logic [7:0] ADDR_STATE    = 8'h18;

  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_PROTO_BIT = 4;
  localparam int CFG_TERM_LSB  = 8;

  localparam logic [13:0] RETRY_RST    = 14'h0001;
  localparam logic [13:0] INTERVAL_RST = 14'h0000;
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic [7:0]  TERM_RST     = 8'h00;

  localparam int EV_RETRY   = 0;
  localparam int EV_LOSS    = 1;
  localparam int EV_RXERR   = 2;
  localparam int EV_RESTART = 3;
  localparam int EV_W       = 4;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_COAST, ST_DECEL, ST_HELD, ST_AUTO_DECEL, ST_AUTO_WAIT
  } cfs_state_t;
endpackage
`default_nettype wire

// *** logic/cfs_supervisor.sv ***
/*
 * Serial link fault supervisor of a motor drive: receive error retry
 * counting, signal-loss timer, stop mode sequencing, alarm terminal,
 * registers and interrupt.
 * Assumes frame and error strobes from the receiver, synchronous inputs.
 */
// Function
// R1 - Consecutive errors over limit trip the drive
// R2 - Limit 9999: alarm only, never trip
// R3 - Alarm terminal: code 98 high, 198 low
// R4 - Retry counting only with computer link protocol
// R5 - Signal loss raises fault and trips
// R6 - Interval 9999 disables loss detection
// R7 - Interval 0 faults on entering link mode
// R8 - Loss timeout equals configured interval
// R9 - Master sends a frame every interval
// R10 - Any received frame clears loss counter
// R11 - Loss checking starts at first frame
// R12 - Settings writable if group zero or option
// R13 - Stop modes: coast, decel, decel with restart
// R14 - Restart uses commands from before fault
// R15 - Clearing during deceleration accelerates again
// R16 - History recorded only with fault output
// R17 - Good frame clears error count
// R18 - Fault held until drive reset
`default_nettype none
`timescale 1ns/100ps
module cfs_supervisor #(
  parameter int TICK_CYCLES = cfs_pkg::LOSS_TICK_CYCLES
) (
  input  wire logic        clock,            // 100 MHz clock
  input  wire logic        rst_n,            // Async reset, active low
  input  wire logic [7:0]  addr,             // Register byte address
  input  wire logic [31:0] wdata,            // Write data
  input  wire logic        wr_en,            // Write strobe
  input  wire logic        rd_en,            // Read strobe
  output logic      [31:0] rdata,            // Read data, cycle after rd_en
  input  wire logic        frame_ok,         // Frame received without error
  input  wire logic        rx_error,         // Frame received with error
  input  wire logic        link_cmd_mode,    // Link is valid command source
  input  wire logic        option_connected, // Communication option present
  input  wire logic        motor_stopped,    // Deceleration finished
  input  wire logic        drive_reset,      // Drive reset pulse
  input  wire logic        run_cmd_in,       // Run command from host
  input  wire logic [15:0] speed_cmd_in,     // Speed command from host
  output logic             link_fault_trip,  // Fault indication
  output logic             fault_output,     // Fault output signal
  output logic             coast_cmd,        // Coast the motor
  output logic             decel_cmd,        // Decelerate and hold stopped
  output logic             run_cmd_out,      // Run command to motor control
  output logic      [15:0] speed_cmd_out,    // Speed command to motor control
  output logic             history_write,    // Store fault in history
  output logic             history_temp,     // Temporary fault display
  output logic             link_error_alarm, // Alarm terminal level
  output logic             irq               // Interrupt, active high
);
  // ==========================================================
  // Settings
  localparam int EV_W = cfs_pkg::EV_W;
  logic [13:0] retry_limit_setting;
  logic [13:0] loss_check_interval;
  logic [1:0]  fault_stop_mode_select;
  logic        protocol_select;
  logic [7:0]  output_terminal_function;
  logic        user_group_read_select;
  logic [EV_W-1:0] status, mask;
  logic        set_ok, wr_retry, wr_intv, wr_cfg;
  assign set_ok   = !user_group_read_select || option_connected; // R12
  assign wr_retry = wr_en && addr == cfs_pkg::ADDR_RETRY && set_ok;
  assign wr_intv  = wr_en && addr == cfs_pkg::ADDR_INTERVAL && set_ok;
  assign wr_cfg   = wr_en && addr == cfs_pkg::ADDR_CONFIG && set_ok;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retry_limit_setting      <= cfs_pkg::RETRY_RST;
      loss_check_interval      <= cfs_pkg::INTERVAL_RST;
      fault_stop_mode_select   <= cfs_pkg::MODE_RST;
      protocol_select          <= 1'b0;
      output_terminal_function <= cfs_pkg::TERM_RST;
      user_group_read_select   <= 1'b0;
      mask                     <= '0;
    end else begin
      if (wr_retry && (wdata[13:0] <= cfs_pkg::RETRY_MAX ||
                       wdata[13:0] == cfs_pkg::SET_OFF)) begin
        retry_limit_setting <= wdata[13:0];
      end
      if (wr_intv && (wdata[13:0] <= cfs_pkg::INTERVAL_MAX ||
                      wdata[13:0] == cfs_pkg::SET_OFF)) begin
        loss_check_interval <= wdata[13:0];
      end
      if (wr_cfg) begin
        fault_stop_mode_select   <= wdata[cfs_pkg::CFG_MODE_LSB +: 2];
        protocol_select          <= wdata[cfs_pkg::CFG_PROTO_BIT];
        output_terminal_function <= wdata[cfs_pkg::CFG_TERM_LSB +: 8];
      end
      if (wr_en && addr == cfs_pkg::ADDR_GROUP) begin
        user_group_read_select <= wdata[0];
      end
      if (wr_en && addr == cfs_pkg::ADDR_MASK) begin
        mask <= wdata[EV_W-1:0];
      end
    end
  end
  // ==========================================================
  // Retry counting and alarm
  logic [3:0] err_count;
  logic       proto_link, retry_off, retry_event, alarm_level;
  assign proto_link  = !protocol_select; // R4
  assign retry_off   = retry_limit_setting == cfs_pkg::SET_OFF;
  assign retry_event = rx_error && proto_link && !retry_off &&
                       {10'h0, err_count} >= retry_limit_setting; // R1
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_count <= 4'h0;
    end else if (drive_reset || frame_ok || !proto_link) begin
      err_count <= 4'h0; // R17
    end else if (rx_error && err_count != 4'hF) begin
      err_count <= err_count + 4'h1; // R1
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_level <= 1'b0;
    end else if (rx_error && proto_link && retry_off) begin
      alarm_level <= 1'b1; // R2
    end else if (frame_ok || drive_reset) begin
      alarm_level <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_error_alarm <= 1'b0;
    end else begin
      link_error_alarm <= (output_terminal_function == cfs_pkg::TERM_POS && alarm_level) ||
                          (output_terminal_function == cfs_pkg::TERM_NEG && !alarm_level); // R3
    end
  end
  // ==========================================================
  // Signal-loss timer, counted in 0.1 s ticks
  logic        tick, frame_seen, loss_armed, loss_off, loss_event;
  logic [13:0] loss_cnt;
  assign frame_seen = frame_ok || rx_error;
  assign loss_off   = loss_check_interval == cfs_pkg::SET_OFF; // R6
  assign loss_event = link_cmd_mode && !loss_off &&
                      (loss_check_interval == 14'h0 || // R7
                       (loss_armed && loss_cnt >= loss_check_interval)); // R8 R5
  cfs_tick_div #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock   (clock),
    .rst_n   (rst_n),
    .restart (frame_seen),
    .tick    (tick)
  );
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loss_armed <= 1'b0;
      loss_cnt   <= 14'h0;
    end else if (!link_cmd_mode || drive_reset) begin
      loss_armed <= 1'b0;
      loss_cnt   <= 14'h0;
    end else if (frame_seen) begin
      loss_armed <= 1'b1;  // R11
      loss_cnt   <= 14'h0; // R10 R9
    end else if (loss_armed && tick && loss_cnt != cfs_pkg::SET_OFF) begin
      loss_cnt <= loss_cnt + 14'h1; // R8
    end
  end

  // ==========================================================
  // Stop mode sequencing
  cfs_pkg::cfs_state_t state, next_state;
  logic        fault_event, saved_run;
  logic [15:0] saved_speed;
  assign fault_event = retry_event || loss_event;
  always_comb begin
    next_state = state;
    case (state)
      cfs_pkg::ST_NORMAL: begin
        if (fault_event) begin
          case (fault_stop_mode_select) // R13
            cfs_pkg::MODE_DECEL: next_state = cfs_pkg::ST_DECEL;
            cfs_pkg::MODE_AUTO:  next_state = cfs_pkg::ST_AUTO_DECEL;
            default:             next_state = cfs_pkg::ST_COAST;
          endcase
        end
      end
      cfs_pkg::ST_DECEL: begin
        if (motor_stopped) begin
          next_state = cfs_pkg::ST_HELD;
        end
      end
      cfs_pkg::ST_AUTO_DECEL: begin
        if (frame_ok) begin
          next_state = cfs_pkg::ST_NORMAL; // R15
        end else if (motor_stopped) begin
          next_state = cfs_pkg::ST_AUTO_WAIT;
        end
      end
      cfs_pkg::ST_AUTO_WAIT: begin
        if (frame_ok) begin
          next_state = cfs_pkg::ST_NORMAL; // R13
        end
      end
      cfs_pkg::ST_COAST, cfs_pkg::ST_HELD: next_state = state; // R18
      default: next_state = cfs_pkg::ST_NORMAL;
    endcase
    if (drive_reset) begin
      next_state = cfs_pkg::ST_NORMAL;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= cfs_pkg::ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end
  // Commands are frozen while faulted, so a restart resumes them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      saved_run   <= 1'b0;
      saved_speed <= 16'h0;
    end else if (state == cfs_pkg::ST_NORMAL && next_state == cfs_pkg::ST_NORMAL) begin
      saved_run   <= run_cmd_in; // R14
      saved_speed <= speed_cmd_in;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_fault_trip <= 1'b0;
      fault_output    <= 1'b0;
      coast_cmd       <= 1'b0;
      decel_cmd       <= 1'b0;
      run_cmd_out     <= 1'b0;
      speed_cmd_out   <= 16'h0;
      history_write   <= 1'b0;
      history_temp    <= 1'b0;
    end else begin
      link_fault_trip <= state == cfs_pkg::ST_COAST || state == cfs_pkg::ST_HELD ||
                         state == cfs_pkg::ST_AUTO_WAIT;
      fault_output    <= state == cfs_pkg::ST_COAST || state == cfs_pkg::ST_HELD; // R13
      coast_cmd       <= state == cfs_pkg::ST_COAST;
      decel_cmd       <= state == cfs_pkg::ST_DECEL || state == cfs_pkg::ST_HELD ||
                         state == cfs_pkg::ST_AUTO_DECEL || state == cfs_pkg::ST_AUTO_WAIT;
      run_cmd_out     <= state == cfs_pkg::ST_NORMAL && saved_run; // R14
      speed_cmd_out   <= state == cfs_pkg::ST_NORMAL ? saved_speed : 16'h0;
      history_write   <= (state == cfs_pkg::ST_COAST || state == cfs_pkg::ST_HELD) &&
                         !fault_output; // R16
      history_temp    <= state == cfs_pkg::ST_AUTO_WAIT; // R16
    end
  end
  // ==========================================================
  // Status, interrupt and read port
  logic [EV_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[cfs_pkg::EV_RETRY]   = state == cfs_pkg::ST_NORMAL && retry_event;
    ev[cfs_pkg::EV_LOSS]    = state == cfs_pkg::ST_NORMAL && loss_event;
    ev[cfs_pkg::EV_RXERR]   = rx_error;
    ev[cfs_pkg::EV_RESTART] = (state == cfs_pkg::ST_AUTO_DECEL ||
                               state == cfs_pkg::ST_AUTO_WAIT) &&
                              next_state == cfs_pkg::ST_NORMAL;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      if (wr_en && addr == cfs_pkg::ADDR_STATUS) begin
        status <= (status & ~wdata[EV_W-1:0]) | ev;
      end else begin
        status <= status | ev;
      end
      irq <= |(status & mask);
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (rd_en) begin
      case (addr)
        cfs_pkg::ADDR_RETRY:    rdata <= {18'h0, retry_limit_setting};
        cfs_pkg::ADDR_INTERVAL: rdata <= {18'h0, loss_check_interval};
        cfs_pkg::ADDR_CONFIG:   rdata <= {16'h0, output_terminal_function, 3'h0,
                                          protocol_select, 2'h0, fault_stop_mode_select};
        cfs_pkg::ADDR_GROUP:    rdata <= {31'h0, user_group_read_select};
        cfs_pkg::ADDR_STATUS:   rdata <= {28'h0, status};
        cfs_pkg::ADDR_MASK:     rdata <= {28'h0, mask};
        cfs_pkg::ADDR_STATE:    rdata <= {loss_cnt, 4'h0, err_count, 5'h0, loss_armed,
                                          alarm_level, 3'(state)};
        default:                rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  retry_trip_a: assert property (state == cfs_pkg::ST_NORMAL && retry_event && // R1
    !drive_reset && fault_stop_mode_select == cfs_pkg::MODE_COAST |=>
    state == cfs_pkg::ST_COAST ##1 coast_cmd) else $error("retry excess did not coast");
  alarm_only_a: assert property (rx_error && retry_off && proto_link && !drive_reset && // R2
    state == cfs_pkg::ST_NORMAL && !loss_event |=> alarm_level && state == cfs_pkg::ST_NORMAL)
    else $error("alarm-only setting misbehaved");
  alarm_pol_a: assert property (output_terminal_function == cfs_pkg::TERM_NEG && // R3
    !alarm_level |=> link_error_alarm) else $error("inverted alarm wrong");
  modbus_ign_a: assert property (protocol_select |-> !retry_event ##1 err_count == 4'h0) // R4
    else $error("retry active under modbus");
  loss_off_a: assert property (loss_off |-> !loss_event) // R6
    else $error("loss detection not disabled");
  zero_imm_a: assert property (link_cmd_mode && loss_check_interval == 14'h0 && // R7
    state == cfs_pkg::ST_NORMAL && !drive_reset |=> state != cfs_pkg::ST_NORMAL)
    else $error("zero interval did not fault");
  loss_clr_a: assert property (frame_seen && link_cmd_mode && !drive_reset |=> // R10
    loss_cnt == 14'h0 && loss_armed) else $error("frame did not clear loss count");
  arm_first_a: assert property (!link_cmd_mode |=> !loss_armed) // R11
    else $error("loss armed outside link mode");
  write_gate_a: assert property (wr_en && addr == cfs_pkg::ADDR_RETRY && // R12
    user_group_read_select && !option_connected |=> $stable(retry_limit_setting))
    else $error("gated write accepted");
  auto_restart_a: assert property (state == cfs_pkg::ST_AUTO_DECEL && frame_ok && // R15
    !drive_reset |=> state == cfs_pkg::ST_NORMAL ##1 !decel_cmd) else $error("no restart");
  hist_out_a: assert property (history_write |-> fault_output ##1 !history_write) // R16
    else $error("history without fault output");
  hold_fault_a: assert property (state == cfs_pkg::ST_HELD && !drive_reset |=> // R18
    state == cfs_pkg::ST_HELD) else $error("held fault released");
endmodule
`default_nettype wire

// *** logic/cfs_tick_div.sv ***
/*
 * Divider giving a one-cycle enable pulse every TICK_CYCLES clocks.
 * Assumes a single free-running clock; restart clears the phase.
 */
`default_nettype none
`timescale 1ns/100ps
module cfs_tick_div #(
  parameter int TICK_CYCLES = cfs_pkg::LOSS_TICK_CYCLES
) (
  input  wire logic clock,   // System clock
  input  wire logic rst_n,   // Async reset, active low
  input  wire logic restart, // Restart the period
  output logic      tick     // One-cycle enable
);
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  logic [31:0] count;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (restart || count == 32'(TICK_CYCLES - 1)) begin
      count <= 32'h0;
      tick  <= !restart;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/cfs_host_model.sv ***
/*
 * Host side of the serial link: sends one good or corrupted frame on
 * request and, while enabled, a good frame every PERIOD cycles.
 * Assumes the bench clock and reset; strobes are one cycle long.
 */
`timescale 1ns/100ps
`default_nettype none
module cfs_host_model #(
  parameter int PERIOD = 40
) (
  input  wire logic clock,    // System clock
  input  wire logic rst_n,    // Async reset, active low
  input  wire logic auto_en,  // Periodic refresh on
  input  wire logic send_ok,  // Send one good frame
  input  wire logic send_err, // Send one corrupted frame
  output logic      frame_ok, // Good frame strobe
  output logic      rx_error  // Corrupted frame strobe
);
  int cnt;

  // ==========================================================
  // Frame strobes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 0;
      frame_ok <= 1'b0;
      rx_error <= 1'b0;
    end else begin
      cnt      <= (auto_en && cnt < PERIOD - 1) ? cnt + 1 : 0;
      frame_ok <= send_ok | (auto_en && cnt == PERIOD - 1);
      rx_error <= send_err;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 * Self-checking bench of the link fault supervisor.
 * Assumes TICK_CYCLES of 20, so one interval unit is 20 clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clock, rst_n, wr_en, rd_en, frame_ok, rx_error, link_cmd_mode;
  logic        option_connected, motor_stopped, drive_reset, run_cmd_in;
  logic        auto_en, send_ok, send_err, link_fault_trip, fault_output;
  logic        coast_cmd, decel_cmd, run_cmd_out, history_write, history_temp;
  logic        link_error_alarm, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed;
  logic [15:0] speed_cmd_in, speed_cmd_out, spd;
  int          num_errors, cmp_count, cyc, hw_seen, lim;

  cfs_supervisor #(.TICK_CYCLES(20)) i_cfs_supervisor (.clock, .rst_n, .addr,
    .wdata, .wr_en, .rd_en, .rdata, .frame_ok, .rx_error, .link_cmd_mode,
    .option_connected, .motor_stopped, .drive_reset, .run_cmd_in, .speed_cmd_in,
    .link_fault_trip, .fault_output, .coast_cmd, .decel_cmd, .run_cmd_out,
    .speed_cmd_out, .history_write, .history_temp, .link_error_alarm, .irq);
  cfs_host_model #(.PERIOD(40)) i_cfs_host_model (.clock, .rst_n, .auto_en,
    .send_ok, .send_err, .frame_ok, .rx_error);

  // ==========================================================
  // Clock, timeout and history pulse count
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (history_write === 1'b1) hw_seen++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chkw(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chkw(nm, e, rdata);
  endtask

  task automatic cfg(input logic [1:0] m, input logic p, input logic [7:0] f);
    wr(cfs_pkg::ADDR_CONFIG, {16'h0000, f, 3'h0, p, 2'h0, m});
  endtask

  task automatic frm(input logic ok, input logic err);
    @(posedge clock);
    send_ok  <= ok;
    send_err <= err;
    @(posedge clock);
    send_ok  <= 1'b0;
    send_err <= 1'b0;
    idle(4);
  endtask

  task automatic dreset();
    @(posedge clock);
    drive_reset <= 1'b1;
    @(posedge clock);
    drive_reset <= 1'b0;
    idle(3);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {clock, rst_n, wr_en, rd_en, link_cmd_mode, option_connected} = 6'h00;
    {motor_stopped, drive_reset, run_cmd_in, auto_en, send_ok, send_err} = 6'h00;
    {addr, wdata, speed_cmd_in} = 56'h0;
    {num_errors, cmp_count, cyc, hw_seen} = 128'h0;
    seed = 32'hC001;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(cfs_pkg::ADDR_RETRY, 32'h1, "retry_rst");
    rd(cfs_pkg::ADDR_INTERVAL, 32'h0, "interval_rst");
    rd(cfs_pkg::ADDR_CONFIG, 32'h0, "config_rst");
    rd(8'hFC, 32'h0, "unmapped");
    wr(cfs_pkg::ADDR_GROUP, 32'h1);
    wr(cfs_pkg::ADDR_RETRY, 32'h5);
    rd(cfs_pkg::ADDR_RETRY, 32'h1, "retry_locked");
    option_connected <= 1'b1;
    wr(cfs_pkg::ADDR_RETRY, 32'h5);
    rd(cfs_pkg::ADDR_RETRY, 32'h5, "retry_option");
    option_connected <= 1'b0;
    wr(cfs_pkg::ADDR_GROUP, 32'h0);
    wr(cfs_pkg::ADDR_RETRY, 32'hB);
    rd(cfs_pkg::ADDR_RETRY, 32'h5, "retry_range");
    $display("test registers done");
    // Retry counting with a random limit, coast mode
    seed = xs(seed);
    lim = int'(seed[1:0]);
    wr(cfs_pkg::ADDR_RETRY, 32'(lim));
    cfg(cfs_pkg::MODE_COAST, 1'b0, 8'h00);
    repeat (lim) frm(1'b0, 1'b1);
    frm(1'b1, 1'b0);
    repeat (lim) frm(1'b0, 1'b1);
    chk1("trip_early", 1'b0, link_fault_trip);
    frm(1'b0, 1'b1);
    chk1("trip", 1'b1, link_fault_trip);
    chk1("coast", 1'b1, coast_cmd);
    chk1("fault_out", 1'b1, fault_output);
    chkw("history", 32'h1, 32'(hw_seen));
    frm(1'b1, 1'b0);
    chk1("trip_held", 1'b1, link_fault_trip);
    dreset();
    chk1("trip_cleared", 1'b0, link_fault_trip);
    cfg(cfs_pkg::MODE_COAST, 1'b1, 8'h00);
    repeat (lim + 3) frm(1'b0, 1'b1);
    chk1("trip_modbus", 1'b0, link_fault_trip);
    $display("test retry done");
    // Alarm only, both terminal polarities, interrupt
    wr(cfs_pkg::ADDR_STATUS, 32'hF);
    wr(cfs_pkg::ADDR_MASK, 32'h4);
    wr(cfs_pkg::ADDR_RETRY, {18'h0, cfs_pkg::SET_OFF});
    cfg(cfs_pkg::MODE_COAST, 1'b0, cfs_pkg::TERM_POS);
    frm(1'b0, 1'b1);
    chk1("alarm_pos", 1'b1, link_error_alarm);
    chk1("no_trip", 1'b0, link_fault_trip);
    chk1("irq_set", 1'b1, irq);
    rd(cfs_pkg::ADDR_STATUS, 32'h4, "status");
    wr(cfs_pkg::ADDR_STATUS, 32'h4);
    idle(2);
    chk1("irq_clr", 1'b0, irq);
    cfg(cfs_pkg::MODE_COAST, 1'b0, cfs_pkg::TERM_NEG);
    idle(2);
    chk1("alarm_neg", 1'b0, link_error_alarm);
    frm(1'b1, 1'b0);
    chk1("alarm_neg_off", 1'b1, link_error_alarm);
    wr(cfs_pkg::ADDR_MASK, 32'h0);
    frm(1'b0, 1'b1);
    chk1("irq_masked", 1'b0, irq);
    $display("test alarm done");
    // Signal loss in decelerate mode, then zero interval in mode 3 (coast)
    wr(cfs_pkg::ADDR_RETRY, 32'hA);
    cfg(cfs_pkg::MODE_DECEL, 1'b0, 8'h00);
    wr(cfs_pkg::ADDR_INTERVAL, 32'h3);
    link_cmd_mode <= 1'b1;
    idle(150);
    chk1("unarmed", 1'b0, decel_cmd);
    auto_en <= 1'b1;
    idle(300);
    chk1("refreshed", 1'b0, decel_cmd);
    auto_en <= 1'b0;
    idle(10);
    chk1("loss_early", 1'b0, decel_cmd);
    idle(110);
    chk1("loss_decel", 1'b1, decel_cmd);
    chk1("decel_no_out", 1'b0, fault_output);
    motor_stopped <= 1'b1;
    idle(4);
    chk1("stop_out", 1'b1, fault_output);
    motor_stopped <= 1'b0;
    dreset();
    wr(cfs_pkg::ADDR_INTERVAL, {18'h0, cfs_pkg::SET_OFF});
    frm(1'b1, 1'b0);
    idle(200);
    chk1("loss_off", 1'b0, decel_cmd);
    link_cmd_mode <= 1'b0;
    wr(cfs_pkg::ADDR_INTERVAL, 32'h0);
    cfg(2'h3, 1'b0, 8'h00);
    idle(3);
    chk1("zero_idle", 1'b0, link_fault_trip);
    link_cmd_mode <= 1'b1;
    idle(5);
    chk1("zero_trip", 1'b1, coast_cmd);
    chk1("mode3_out", 1'b1, fault_output);
    link_cmd_mode <= 1'b0;
    dreset();
    $display("test loss done");
    // Automatic restart mode
    hw_seen = 0;
    wr(cfs_pkg::ADDR_RETRY, 32'h0);
    cfg(cfs_pkg::MODE_AUTO, 1'b0, 8'h00);
    seed = xs(seed);
    spd = seed[15:0];
    run_cmd_in <= 1'b1;
    speed_cmd_in <= spd;
    idle(3);
    chk1("run_pass", 1'b1, run_cmd_out);
    frm(1'b0, 1'b1);
    chk1("auto_decel", 1'b1, decel_cmd);
    chk1("auto_no_out", 1'b0, fault_output);
    frm(1'b1, 1'b0);
    chk1("reaccel", 1'b0, decel_cmd);
    chk1("restart_run", 1'b1, run_cmd_out);
    chkw("restart_speed", {16'h0, spd}, {16'h0, speed_cmd_out});
    frm(1'b0, 1'b1);
    motor_stopped <= 1'b1;
    idle(4);
    chk1("temp_show", 1'b1, history_temp);
    chk1("auto_trip", 1'b1, link_fault_trip);
    motor_stopped <= 1'b0;
    frm(1'b1, 1'b0);
    chk1("temp_gone", 1'b0, history_temp);
    chk1("auto_run", 1'b1, run_cmd_out);
    chkw("no_history", 32'h0, 32'(hw_seen));
    $display("test restart done");
    end_sim();
  end
endmodule
`default_nettype wire
